// *** hw/nib_exec.sv ***
// execution slice: memory alu, immediates, status bits, rom read, call
// Notes on behaviour
// RULE_01: sub gives ram minus acc; cond cleared on borrow, set otherwise.
// RULE_02: acc and not ram; cond set on zero result.
// RULE_03: acc or ram; cond set on zero result; one cycle.
// RULE_04: acc xor ram; cond set on zero result.
// RULE_05: acc plus immediate; cond follows carry out.
// RULE_06: low index plus immediate; cond follows carry out; one cycle.
// RULE_07: bit set writes one to selected status bit.
// RULE_08: bit clear writes zero to selected status bit; one cycle.
// RULE_09: bit set/clear update no flag from their result.
// RULE_10: bit test copies complement of selected bit into cond.
// RULE_11: pointer load two bytes, two cycles; high seven bits from operand, low from ram.
// RULE_12: rom low read loads low nibble, two cycles, flags kept.
// RULE_13: rom high read loads high nibble then bumps pointer, two cycles.
// RULE_14: four-level return stack shared by calls and interrupts.
// RULE_15: fourth level is the rom pointer; software keeps nesting at three.
// RULE_16: no interrupt accepted while four levels are occupied.
// RULE_17: call at four levels does not push the program counter.
// RULE_18: two-byte call pushes return address, loads eleven-bit target.
// RULE_19: bit ops hit status word unless index redirects them.
// RULE_20: ram operand address is high:low index unless redirected.
// RULE_21: four-bit results wrap modulo sixteen.
`timescale 1ns/100ps
`default_nettype none
module nib_exec #(
   parameter int AW = 11
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // instruction stream
   input wire logic instr_valid_i,
   input wire logic [7:0] instr_i,
   output logic instr_ready_o,
   // index redirection
   input wire nib_core_pkg::index_ctl_s index_i,
   // ram
   output nib_core_pkg::ram_addr_s ram_addr_o,
   input wire logic [3:0] ram_rdata_i,
   output logic ram_we_o,
   output logic [3:0] ram_wdata_o,
   // other register or port for redirected bit ops
   input wire logic [3:0] alt_rdata_i,
   output logic alt_we_o,
   output logic [3:0] alt_wdata_o,
   // rom data read
   output logic [AW-1:0] rom_addr_o,
   input wire logic [7:0] rom_data_i,
   // interrupt request gating
   input wire logic irq_i,
   output logic irq_taken_o,
   input wire logic [AW-1:0] irq_vector_i,
   // return from stack
   input wire logic ret_i,
   // state view
   output logic [3:0] acc_o,
   output logic [3:0] flag_word_o,
   output logic [3:0] low_index_o,
   output logic [3:0] high_index_o,
   output logic [AW-1:0] pc_o,
   output logic [2:0] stack_level_o
);
   typedef enum logic [1:0] {
      S_FETCH = 2'b00,
      S_SECOND = 2'b01,
      S_ROMWAIT = 2'b10
   } ph_e;

   ph_e ph_reg;
   logic [7:0] op_reg;
   logic [3:0] acc_reg;
   logic [3:0] flag_word_reg;
   logic [3:0] low_index_reg;
   logic [3:0] high_index_reg;
   logic [AW-1:0] pc_reg;
   logic [AW-1:0] rom_pointer;
   logic [AW-1:0] stk_top;
   logic [2:0] stk_level;
   logic push, pop, ptr_wr;
   logic [AW-1:0] ptr_next;
   logic [AW-1:0] push_data;
   logic stk_full;
   logic [4:0] sum_a, sum_l, diff;

   if (AW != 11)
   begin : g_bad_aw
      $error("address width must be 11");
   end

   function automatic logic [3:0] bit_mask(input logic [1:0] b);
      bit_mask = 4'h1 << b;
   endfunction : bit_mask

   function automatic logic is_zero(input logic [3:0] v);
      is_zero = (v == 4'h0);
   endfunction : is_zero

   wire logic take = instr_valid_i && ph_reg == S_FETCH;
   wire logic [7:0] op = instr_i;
   wire logic is_bset = op[7:2] == nib_core_pkg::OPC_BSET_HI;
   wire logic is_bclr = op[7:2] == nib_core_pkg::OPC_BCLR_HI;
   wire logic is_btst = op[7:2] == nib_core_pkg::OPC_BTST_HI;
   wire logic bit_to_flags = index_i.target == nib_core_pkg::TGT_FLAGS;
   wire logic bit_to_ram = index_i.target == nib_core_pkg::TGT_RAM;
   wire logic [3:0] test_src = bit_to_ram ? ram_rdata_i
                               : (bit_to_flags ? flag_word_reg : alt_rdata_i);

   assign instr_ready_o = ph_reg == S_FETCH;
   assign stk_full = stk_level == nib_core_pkg::STK_FULL_LVL;

   // ram operand address
   always_comb
   begin
      ram_addr_o.high = high_index_reg; // RULE_20
      ram_addr_o.low = low_index_reg;
      if (index_i.use_alt_addr)
         ram_addr_o = index_i.alt_addr;
   end

   // wrapping arithmetic with carry/borrow in bit 4
   assign sum_a = {1'b0, acc_reg} + {1'b0, op[3:0]}; // RULE_05 RULE_21
   assign sum_l = {1'b0, low_index_reg} + {1'b0, op[3:0]}; // RULE_06 RULE_21
   assign diff = {1'b0, ram_rdata_i} - {1'b0, acc_reg}; // RULE_01 RULE_21

   // accumulator
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         acc_reg <= 4'h0;
      else if (take)
      begin
         unique case (1'b1)
            op == nib_core_pkg::OPC_SUB: acc_reg <= diff[3:0]; // RULE_01
            op == nib_core_pkg::OPC_ANDN: acc_reg <= acc_reg & ~ram_rdata_i; // RULE_02
            op == nib_core_pkg::OPC_OR: acc_reg <= acc_reg | ram_rdata_i; // RULE_03
            op == nib_core_pkg::OPC_XOR: acc_reg <= acc_reg ^ ram_rdata_i; // RULE_04
            op[7:4] == nib_core_pkg::OPC_ADDA_HI: acc_reg <= sum_a[3:0]; // RULE_05
            default: acc_reg <= acc_reg;
         endcase
      end
      else if (ph_reg == S_ROMWAIT)
         acc_reg <= (op_reg == nib_core_pkg::OPC_ROMHI) ? rom_data_i[7:4]
                    : rom_data_i[3:0]; // RULE_12 RULE_13
   end

   // status word: cond bit plus bit ops
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         flag_word_reg <= 4'h0;
      else if (take)
      begin
         unique case (1'b1)
            op == nib_core_pkg::OPC_SUB:
               flag_word_reg[nib_core_pkg::COND_BIT] <= ~diff[4]; // RULE_01
            op == nib_core_pkg::OPC_ANDN:
               flag_word_reg[nib_core_pkg::COND_BIT] <= is_zero(acc_reg & ~ram_rdata_i); // RULE_02
            op == nib_core_pkg::OPC_OR:
               flag_word_reg[nib_core_pkg::COND_BIT] <= is_zero(acc_reg | ram_rdata_i); // RULE_03
            op == nib_core_pkg::OPC_XOR:
               flag_word_reg[nib_core_pkg::COND_BIT] <= is_zero(acc_reg ^ ram_rdata_i); // RULE_04
            op[7:4] == nib_core_pkg::OPC_ADDA_HI:
               flag_word_reg[nib_core_pkg::COND_BIT] <= sum_a[4]; // RULE_05
            op[7:4] == nib_core_pkg::OPC_ADDL_HI:
               flag_word_reg[nib_core_pkg::COND_BIT] <= sum_l[4]; // RULE_06
            is_bset && bit_to_flags:
               flag_word_reg <= flag_word_reg | bit_mask(op[1:0]); // RULE_07 RULE_09 RULE_19
            is_bclr && bit_to_flags:
               flag_word_reg <= flag_word_reg & ~bit_mask(op[1:0]); // RULE_08 RULE_09 RULE_19
            is_btst:
               flag_word_reg[nib_core_pkg::COND_BIT] <= ~test_src[op[1:0]]; // RULE_10
            default: flag_word_reg <= flag_word_reg;
         endcase
      end
   end

   // redirected bit set/clear to ram or another register/port
   always_comb
   begin
      ram_we_o = 1'b0;
      alt_we_o = 1'b0;
      ram_wdata_o = is_bset ? (ram_rdata_i | bit_mask(op[1:0]))
                    : (ram_rdata_i & ~bit_mask(op[1:0]));
      alt_wdata_o = is_bset ? (alt_rdata_i | bit_mask(op[1:0]))
                    : (alt_rdata_i & ~bit_mask(op[1:0]));
      if (take && (is_bset || is_bclr) && !bit_to_flags)
      begin
         ram_we_o = bit_to_ram; // RULE_19
         alt_we_o = !bit_to_ram;
      end
   end

   // low index register
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         low_index_reg <= 4'h0;
      else if (take && op[7:4] == nib_core_pkg::OPC_ADDL_HI)
         low_index_reg <= sum_l[3:0]; // RULE_06
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         high_index_reg <= 4'h0;
   end

   // phase sequencing for two-cycle instructions
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         ph_reg <= S_FETCH;
      else
      begin
         unique case (ph_reg)
            S_FETCH:
               if (take && (op == nib_core_pkg::OPC_ROMPTR
                            || op[7:3] == nib_core_pkg::OPC_CALL_HI))
                  ph_reg <= S_SECOND; // RULE_11 RULE_18
               else if (take && (op == nib_core_pkg::OPC_ROMLO
                                 || op == nib_core_pkg::OPC_ROMHI))
                  ph_reg <= S_ROMWAIT; // RULE_12 RULE_13
            S_SECOND:
               if (instr_valid_i)
                  ph_reg <= S_FETCH;
            S_ROMWAIT:
               ph_reg <= S_FETCH;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         op_reg <= 8'h00;
      else if (take)
         op_reg <= op;
   end

   // rom pointer writes and stack control
   always_comb
   begin
      ptr_wr = 1'b0;
      ptr_next = rom_pointer;
      push_data = irq_taken_o ? pc_reg : pc_reg + 11'h001; // irq resumes the unrun instruction
      push = 1'b0;
      pop = ret_i && ph_reg == S_FETCH;
      if (ph_reg == S_SECOND && instr_valid_i && op_reg == nib_core_pkg::OPC_ROMPTR)
      begin
         ptr_wr = 1'b1;
         ptr_next = {instr_i[6:0], ram_rdata_i}; // RULE_11
      end
      else if (ph_reg == S_ROMWAIT && op_reg == nib_core_pkg::OPC_ROMHI)
      begin
         ptr_wr = 1'b1;
         ptr_next = rom_pointer + 11'h001; // RULE_13
      end
      if (ph_reg == S_SECOND && instr_valid_i && op_reg[7:3] == nib_core_pkg::OPC_CALL_HI)
         push = !stk_full; // RULE_17 RULE_18
      else if (irq_taken_o)
         push = 1'b1; // RULE_14
   end

   // interrupts refused at full nesting
   assign irq_taken_o = irq_i && ph_reg == S_FETCH && !instr_valid_i && !ret_i
                        && !stk_full; // RULE_16

   // program counter
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         pc_reg <= '0;
      else if (ph_reg == S_SECOND && instr_valid_i && op_reg[7:3] == nib_core_pkg::OPC_CALL_HI)
         pc_reg <= {op_reg[2:0], instr_i}; // RULE_18
      else if (irq_taken_o)
         pc_reg <= irq_vector_i;
      else if (pop)
         pc_reg <= stk_top;
      else if (take || (ph_reg == S_SECOND && instr_valid_i))
         pc_reg <= pc_reg + 11'h001;
   end

   nib_ret_stack #(
      .AW(AW),
      .DEPTH(4)
   ) u_stack (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .push_i(push),
      .pop_i(pop),
      .push_data_i(push_data), // RULE_15
      .ptr_wr_i(ptr_wr),
      .ptr_data_i(ptr_next),
      .top_o(stk_top),
      .ptr_o(rom_pointer),
      .level_o(stk_level)
   );

   assign rom_addr_o = rom_pointer;
   assign acc_o = acc_reg;
   assign flag_word_o = flag_word_reg;
   assign low_index_o = low_index_reg;
   assign high_index_o = high_index_reg;
   assign pc_o = pc_reg;
   assign stack_level_o = stk_level;

   AST_OR_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_03
      take && op == nib_core_pkg::OPC_OR |=> flag_word_reg[0] == is_zero(acc_reg))
      else $error("or zero flag wrong");
   AST_SUB_VAL: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_01
      take && op == nib_core_pkg::OPC_SUB |=> acc_reg == 4'($past(ram_rdata_i) - $past(acc_reg)))
      else $error("sub result wrong");
   AST_ADDI_CARRY: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_05
      take && op[7:4] == nib_core_pkg::OPC_ADDA_HI |=> flag_word_reg[0] == ($past(acc_reg) > ~$past(op[3:0])))
      else $error("add carry wrong");
   AST_BSET: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_07
      take && is_bset && bit_to_flags |=> flag_word_reg[$past(op[1:0])])
      else $error("bit not set");
   AST_BCLR: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_08
      take && is_bclr && bit_to_flags |=> !flag_word_reg[$past(op[1:0])])
      else $error("bit not cleared");
   AST_FULL_NO_IRQ: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_16
      stk_full |-> !irq_taken_o)
      else $error("irq at full stack");
   AST_FULL_NO_PUSH: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_17
      stk_full && !ptr_wr |=> stk_level <= nib_core_pkg::STK_FULL_LVL && rom_pointer == $past(rom_pointer))
      else $error("stack overflow");
   sequence rom_hi_tail;
      ph_reg == S_ROMWAIT ##1 (ph_reg == S_FETCH && rom_pointer == $past(rom_pointer) + 11'h001);
   endsequence
   AST_ROM_TWO: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_13
      take && op == nib_core_pkg::OPC_ROMHI |=> rom_hi_tail)
      else $error("rom high read sequence wrong");
endmodule : nib_exec
`default_nettype wire

// *** hw/nib_ret_stack.sv ***
// four-entry return address stack, fourth entry shared with rom pointer
`timescale 1ns/100ps
`default_nettype none
module nib_ret_stack #(
   parameter int AW = 11,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // push / pop
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic [AW-1:0] push_data_i,
   // rom pointer shares the last slot
   input wire logic ptr_wr_i,
   input wire logic [AW-1:0] ptr_data_i,
   // state
   output logic [AW-1:0] top_o,
   output logic [AW-1:0] ptr_o,
   output logic [2:0] level_o
);
   logic [AW-1:0] mem_reg [DEPTH];
   logic [2:0] level_reg;
   if (DEPTH != 4)
   begin : g_bad_depth
      $error("stack depth must be 4");
   end
   // occupancy; popping an empty stack stays empty
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         level_reg <= 3'h0;
      else if (push_i && level_reg != 3'(DEPTH))
         level_reg <= level_reg + 3'h1;
      else if (pop_i && level_reg != 3'h0)
         level_reg <= level_reg - 3'h1;
   end
   // storage; the deepest slot is also the rom pointer
   always_ff @(posedge clk_i)
   begin
      if (push_i && level_reg != 3'(DEPTH))
         mem_reg[level_reg[1:0]] <= push_data_i;
      else if (ptr_wr_i)
         mem_reg[DEPTH-1] <= ptr_data_i;
   end
   // registered read of the top entry
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         top_o <= '0;
      else if (level_reg != 3'h0)
         top_o <= mem_reg[level_reg[1:0] - 2'h1];
   end
   assign ptr_o = mem_reg[DEPTH-1];
   assign level_o = level_reg;
endmodule : nib_ret_stack
`default_nettype wire

// *** pkg/nib_core_pkg.sv ***
// constants and carriers for the nibble core execution slice
package nib_core_pkg;
   // opcodes (first byte)
   localparam logic [7:0] OPC_SUB = 8'h3d;
   localparam logic [7:0] OPC_ANDN = 8'h3c;
   localparam logic [7:0] OPC_OR = 8'h3e;
   localparam logic [7:0] OPC_XOR = 8'h3f;
   localparam logic [7:0] OPC_ROMPTR = 8'h20;
   localparam logic [7:0] OPC_ROMLO = 8'h31;
   localparam logic [7:0] OPC_ROMHI = 8'h32;
   localparam logic [3:0] OPC_ADDA_HI = 4'h4;
   localparam logic [3:0] OPC_ADDL_HI = 4'h5;
   localparam logic [5:0] OPC_BSET_HI = 6'h05;
   localparam logic [5:0] OPC_BCLR_HI = 6'h06;
   localparam logic [5:0] OPC_BTST_HI = 6'h07;
   localparam logic [4:0] OPC_CALL_HI = 5'h19;
   // targets of the bit operations
   localparam logic [1:0] TGT_FLAGS = 2'h0;
   localparam logic [1:0] TGT_OTHER = 2'h1;
   localparam logic [1:0] TGT_RAM = 2'h2;
   localparam logic [1:0] TGT_PORT = 2'h3;
   // status word bit holding the branch condition
   localparam int COND_BIT = 0;
   localparam logic [2:0] STK_DEPTH = 3'h4;
   localparam logic [2:0] STK_FULL_LVL = 3'h4;
   // ram address source
   typedef struct packed {
      logic [3:0] high;
      logic [3:0] low;
   } ram_addr_s;
   // bit-op redirection from an index instruction
   typedef struct packed {
      logic [1:0] target;
      logic use_alt_addr;
      ram_addr_s alt_addr;
   } index_ctl_s;
endpackage : nib_core_pkg

// *** verif/nibble_cpu_alu_bit_rom_call_ops_bench.sv ***
// self-checking bench for the nibble core execution slice
`timescale 1ns/100ps
`default_nettype none
`define CK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin err_total++; \
   $display("[ERR] %s exp %h got %h", nm, e, a); end end
module nibble_cpu_alu_bit_rom_call_ops_bench;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic instr_valid_i = 1'b0;
   logic irq_i = 1'b0;
   logic ret_i = 1'b0;
   logic [7:0] instr_i = 8'h00;
   logic [7:0] rom_data_i = 8'h00;
   logic [3:0] ram_rdata_i = 4'h0;
   logic [3:0] alt_rdata_i = 4'h0;
   logic [10:0] irq_vector_i = 11'h155;
   nib_core_pkg::index_ctl_s index_i = '0;
   nib_core_pkg::ram_addr_s ram_addr_o;
   logic instr_ready_o, ram_we_o, alt_we_o, irq_taken_o;
   logic [3:0] ram_wdata_o, alt_wdata_o, acc_o, flag_word_o, low_index_o, high_index_o;
   logic [10:0] rom_addr_o, pc_o;
   logic [2:0] stack_level_o;
   int err_total = 0;
   int total_checks = 0;
   int seen_ram = 0;
   int seen_alt = 0;
   logic [3:0] seen_wd = 4'h0;
   logic [10:0] p0;

   always #2.5 clk_i = ~clk_i;

   nib_exec uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
      .instr_i(instr_i), .instr_ready_o(instr_ready_o), .index_i(index_i),
      .ram_addr_o(ram_addr_o), .ram_rdata_i(ram_rdata_i), .ram_we_o(ram_we_o),
      .ram_wdata_o(ram_wdata_o), .alt_rdata_i(alt_rdata_i), .alt_we_o(alt_we_o),
      .alt_wdata_o(alt_wdata_o), .rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i),
      .irq_i(irq_i), .irq_taken_o(irq_taken_o), .irq_vector_i(irq_vector_i),
      .ret_i(ret_i), .acc_o(acc_o), .flag_word_o(flag_word_o), .low_index_o(low_index_o),
      .high_index_o(high_index_o), .pc_o(pc_o), .stack_level_o(stack_level_o));

   // redirected write strobes are one-cycle pulses, so catch them at every edge
   always @(posedge clk_i)
   begin
      if (ram_we_o === 1'b1)
      begin
         seen_ram++;
         seen_wd = ram_wdata_o;
      end
      if (alt_we_o === 1'b1)
      begin
         seen_alt++;
         seen_wd = alt_wdata_o;
      end
   end

   task automatic stop_test;
      if (err_total == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : stop_test

   // offer one byte; part 1 opens a pair, part 2 is its second byte,
   // which the core takes at the next edge while ready stays low
   task automatic send(input logic [7:0] b, input logic [3:0] r, input logic [1:0] part);
      int n;
      n = 0;
      @(posedge clk_i);
      instr_valid_i <= 1'b1;
      instr_i <= b;
      ram_rdata_i <= r;
      #1;
      while (part != 2'h2 && instr_ready_o !== 1'b1 && n < 20)
      begin
         @(posedge clk_i);
         #1;
         n++;
      end
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      if (part != 2'h1)
      begin
         @(posedge clk_i);
         #1;
         while (instr_ready_o !== 1'b1 && n < 40)
         begin
            @(posedge clk_i);
            #1;
            n++;
         end
         `CK("ready", 1'b1, instr_ready_o)
      end
   endtask : send

   task automatic step(input logic [7:0] op, input logic [3:0] r, input logic [3:0] acc,
                       input logic [3:0] lo, input logic [3:0] fl);
      send(op, r, 2'h0);
      `CK("acc", acc, acc_o)
      `CK("low", lo, low_index_o)
      `CK("flags", fl, flag_word_o)
      `CK("raddr", {high_index_o, low_index_o}, ram_addr_o)
   endtask : step

   task automatic redir(input nib_core_pkg::index_ctl_s ix, input logic [7:0] op,
                        input logic [3:0] r, input logic [3:0] exp, input logic to_ram);
      @(posedge clk_i);
      index_i <= ix;
      alt_rdata_i <= r;
      seen_ram = 0;
      seen_alt = 0;
      send(op, r, 2'h0);
      if (to_ram)
         `CK("alt_addr", ix.alt_addr, ram_addr_o)
      @(posedge clk_i);
      index_i <= '0;
      `CK("ram_we", to_ram ? 1 : 0, seen_ram)
      `CK("alt_we", to_ram ? 0 : 1, seen_alt)
      `CK("wdata", exp, seen_wd)
      `CK("flags", 4'h2, flag_word_o)
   endtask : redir

   task automatic call(input logic [10:0] a, input logic [2:0] lvl);
      send({nib_core_pkg::OPC_CALL_HI, a[10:8]}, 4'h0, 2'h1);
      send(a[7:0], 4'h0, 2'h2);
      `CK("lvl", lvl, stack_level_o)
   endtask : call

   task automatic ret(input logic [10:0] pc, input logic [2:0] lvl);
      @(posedge clk_i);
      ret_i <= 1'b1;
      @(posedge clk_i);
      ret_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      `CK("ret_pc", pc, pc_o)
      `CK("lvl", lvl, stack_level_o)
   endtask : ret

   task automatic irq_run;
      int n;
      n = 0;
      @(posedge clk_i);
      irq_i <= 1'b1;
      // the acceptance strobe stands only until the edge that takes it
      #1;
      `CK("irq_taken", 1'b1, irq_taken_o)
      @(posedge clk_i);
      irq_i <= 1'b0;
      #1;
      `CK("lvl", 3'h4, stack_level_o)
      `CK("irq_pc", irq_vector_i, pc_o)
      `CK("rom_ptr", 11'h7ff, rom_addr_o)
      n = 0;
      @(posedge clk_i);
      irq_i <= 1'b1;
      repeat (6)
      begin
         @(posedge clk_i);
         #1;
         if (irq_taken_o === 1'b1)
            n++;
      end
      `CK("irq_refused", 0, n)
      @(posedge clk_i);
      irq_i <= 1'b0;
   endtask : irq_run

   initial
   begin
      #100000;
      err_total++;
      stop_test();
   end

   initial
   begin
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      step(8'h47, 4'h0, 4'h7, 4'h0, 4'h0);
      step(8'h4a, 4'h0, 4'h1, 4'h0, 4'h1);
      step(8'h3d, 4'h0, 4'hf, 4'h0, 4'h0);
      step(8'h3d, 4'hf, 4'h0, 4'h0, 4'h1);
      step(8'h3e, 4'h0, 4'h0, 4'h0, 4'h1);
      step(8'h3e, 4'h9, 4'h9, 4'h0, 4'h0);
      step(8'h3c, 4'h2, 4'h9, 4'h0, 4'h0);
      step(8'h3c, 4'h9, 4'h0, 4'h0, 4'h1);
      step(8'h3f, 4'h6, 4'h6, 4'h0, 4'h0);
      step(8'h3f, 4'h6, 4'h0, 4'h0, 4'h1);
      step(8'h59, 4'h0, 4'h0, 4'h9, 4'h0);
      step(8'h57, 4'h0, 4'h0, 4'h0, 4'h1);
      step(8'h17, 4'h0, 4'h0, 4'h0, 4'h9);
      step(8'h1c, 4'h0, 4'h0, 4'h0, 4'h8);
      step(8'h1d, 4'h0, 4'h0, 4'h0, 4'h9);
      step(8'h18, 4'h0, 4'h0, 4'h0, 4'h8);
      step(8'h1b, 4'h0, 4'h0, 4'h0, 4'h0);
      step(8'h15, 4'h0, 4'h0, 4'h0, 4'h2);
      redir('{2'h2, 1'b1, '{4'h3, 4'hc}}, 8'h16, 4'h1, 4'h5, 1'b1);
      redir('{2'h1, 1'b0, '{4'h0, 4'h0}}, 8'h18, 4'hf, 4'he, 1'b0);
      redir('{2'h3, 1'b0, '{4'h0, 4'h0}}, 8'h17, 4'h0, 4'h8, 1'b0);
      send(nib_core_pkg::OPC_ROMPTR, 4'h0, 2'h1);
      send(8'h7f, 4'ha, 2'h2);
      `CK("rom_ptr", 11'h7fa, rom_addr_o)
      @(posedge clk_i);
      rom_data_i <= 8'h5c;
      step(8'h31, 4'h0, 4'hc, 4'h0, 4'h2);
      step(8'h32, 4'h0, 4'h5, 4'h0, 4'h2);
      `CK("rom_ptr", 11'h7fb, rom_addr_o)
      p0 = pc_o;
      call(11'h123, 3'h1);
      `CK("pc", 11'h123, pc_o)
      call(11'h456, 3'h2);
      call(11'h7ff, 3'h3);
      `CK("pc", 11'h7ff, pc_o)
      `CK("rom_ptr", 11'h7fb, rom_addr_o)
      irq_run();
      call(11'h0aa, 3'h4);
      `CK("rom_ptr", 11'h7ff, rom_addr_o)
      ret(11'h7ff, 3'h3);
      ret(11'h458, 3'h2);
      ret(11'h125, 3'h1);
      ret(p0 + 11'h2, 3'h0);
      stop_test();
   end
endmodule : nibble_cpu_alu_bit_rom_call_ops_bench
`default_nettype wire
